// File: rtl/sbcts_params.svh
// timing constants and reset values for the sbc timing supervisor
`ifndef SBCTS_PARAMS_SVH
`define SBCTS_PARAMS_SVH

// ------------------------------------------------------------
// clock and internal oscillator
// ------------------------------------------------------------
`define SBCTS_CLK_MHZ            250
`define SBCTS_OSC_KHZ            512
`define SBCTS_OSC_DIV            ((`SBCTS_CLK_MHZ * 1000) / `SBCTS_OSC_KHZ)
`define SBCTS_TICKS(us)          (((us) * `SBCTS_OSC_KHZ) / 1000)
`define SBCTS_CNT_W              22
`define SBCTS_NWP_W              3

// ------------------------------------------------------------
// times; mid-range so the limits hold over oscillator spread
// ------------------------------------------------------------
`define SBCTS_T_RST_LONG_US      22500
`define SBCTS_T_RST_SHORT_US     4300
`define SBCTS_T_CLAMP_US         117000
`define SBCTS_T_WATCHDOG_DISABLE_PIN_US         1600
`define SBCTS_T_WAKE_US          25
`define SBCTS_T_CAN_PULSE_NS     1750
`define SBCTS_T_CAN_WAKE_TO_US   800
`define SBCTS_T_CAN_TXD_US       3150
`define SBCTS_T_LIN_TXD_US       50000
`define SBCTS_T_LIN_WAKE_US      66
`define SBCTS_T_WB_LOW_US        252
`define SBCTS_T_WB_CY_LONG_US    64650
`define SBCTS_T_WB_CY_SHORT_US   16150

// ------------------------------------------------------------
// derived counts
// ------------------------------------------------------------
`define SBCTS_RST_LONG_TICKS     `SBCTS_TICKS(`SBCTS_T_RST_LONG_US)
`define SBCTS_RST_SHORT_TICKS    `SBCTS_TICKS(`SBCTS_T_RST_SHORT_US)
`define SBCTS_CLAMP_TICKS        `SBCTS_TICKS(`SBCTS_T_CLAMP_US)
`define SBCTS_WATCHDOG_DISABLE_PIN_TICKS        `SBCTS_TICKS(`SBCTS_T_WATCHDOG_DISABLE_PIN_US)
`define SBCTS_WAKE_TICKS         `SBCTS_TICKS(`SBCTS_T_WAKE_US)
`define SBCTS_CAN_PULSE_CYC      ((`SBCTS_T_CAN_PULSE_NS * `SBCTS_CLK_MHZ) / 1000)
`define SBCTS_CAN_WAKE_TO_TICKS  `SBCTS_TICKS(`SBCTS_T_CAN_WAKE_TO_US)
`define SBCTS_CAN_TXD_TICKS      `SBCTS_TICKS(`SBCTS_T_CAN_TXD_US)
`define SBCTS_LIN_TXD_TICKS      `SBCTS_TICKS(`SBCTS_T_LIN_TXD_US)
`define SBCTS_LIN_WAKE_TICKS     `SBCTS_TICKS(`SBCTS_T_LIN_WAKE_US)
`define SBCTS_WB_LOW_TICKS       `SBCTS_TICKS(`SBCTS_T_WB_LOW_US)
`define SBCTS_WB_CY_LONG_TICKS   `SBCTS_TICKS(`SBCTS_T_WB_CY_LONG_US)
`define SBCTS_WB_CY_SHORT_TICKS  `SBCTS_TICKS(`SBCTS_T_WB_CY_SHORT_US)
`define SBCTS_WD_MS_TICKS        `SBCTS_OSC_KHZ

// ------------------------------------------------------------
// nominal watchdog periods per field code, in ms
// ------------------------------------------------------------
`define SBCTS_WD_P0_MS           8
`define SBCTS_WD_P1_MS           16
`define SBCTS_WD_P2_MS           32
`define SBCTS_WD_P3_MS           64
`define SBCTS_WD_P4_MS           128
`define SBCTS_WD_P5_MS           256
`define SBCTS_WD_P6_MS           1024
`define SBCTS_WD_P7_MS           4096

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define SBCTS_RST_ACTIVE_INIT    1'h1
`define SBCTS_WAKE_FILT_INIT     2'h0
`define SBCTS_WATCHDOG_DISABLE_PIN_INIT         1'h0
`define SBCTS_WAKE_BIAS_OUTPUT_INIT         1'h0

`endif

// File: rtl/sbcts_pkg.sv
// shared types for the sbc timing supervisor
`include "sbcts_params.svh"
package sbcts_pkg;

	typedef logic [`SBCTS_CNT_W-1:0] sbcts_cnt_type;

	typedef enum logic [2:0] {
		SBCTS_NORMAL  = 3'h1,
		SBCTS_STANDBY = 3'h2,
		SBCTS_SLEEP   = 3'h4
	} sbcts_mode_type;

	typedef enum logic [3:0] {
		CW_IDLE = 4'h1,
		CW_REC  = 4'h2,
		CW_DOM  = 4'h4,
		CW_CONF = 4'h8
	} sbcts_canwk_type;

	typedef struct packed {
		logic local_a;
		logic local_b;
		logic can;
		logic lin_a;
		logic lin_b;
	} sbcts_wake_type;

	typedef struct packed {
		logic reset_clamp;
		logic supply_clamp;
		logic can_tx_timeout;
		logic lin_a_tx_timeout;
		logic lin_b_tx_timeout;
	} sbcts_fault_type;

endpackage

// File: rtl/sbcts_hold_timer.sv
// hold timer: flags a condition that has lasted a number of oscillator ticks
`timescale 1ns/1ps
`default_nettype none
module sbcts_hold_timer
	import sbcts_pkg::*;
(
	// clock and reset
	input  wire logic          clk_sys,
	input  wire logic          sys_rst,
	// timing
	input  wire logic          tick,
	input  wire logic          hold,
	input  wire sbcts_cnt_type limit,
	// result
	output logic               expired
);

	sbcts_cnt_type cnt;

	// any break in the condition starts the count again
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			cnt <= '0;
		else if (!hold)
			cnt <= '0;
		else if (tick && (cnt < limit))
			cnt <= cnt + 1'b1;
	end

	assign expired = hold && (cnt >= limit);

endmodule // sbcts_hold_timer
`default_nettype wire

// File: rtl/sbcts_timing_supervisor.sv
// timing supervisor: watchdog, reset pulse, clamps, filters, wake-up, time-outs, wake bias
//
// Operation
// - in window mode a trigger before half the nominal period in Normal mode forces a system reset.
// - a trigger between half and the full nominal period restarts the watchdog without reset.
// - no trigger within the nominal period means overflow and a system reset.
// - the early limit holds in Normal mode only, the overflow limit in all modes, both in window mode only.
// - the nominal period comes from the period field written by the microcontroller.
// - the reset pulse lasts 20 to 25 ms with a weak pull-up and 3.6 to 5 ms with a 1 kOhm pull-up.
// - with the watchdog enabled a reset pin held low while released for 95 to 140 ms is flagged.
// - with supply and watchdog on, the supply below 0.9 of nominal for 95 to 140 ms is flagged.
// - a local wake input change counts as wake-up only after 10 to 40 us of stability.
// - CAN wake-up in Sleep needs alternating recessive and dominant pulses each above 0.5 to 3 us.
// - the CAN wake pattern is dropped when its parts are more than 0.4 to 1.2 ms apart.
// - an online CAN transmit input held low longer than 1.8 to 4.5 ms is flagged.
// - an online LIN transmit input held low longer than 20 to 80 ms is flagged.
// - LIN wake-up needs the bus dominant longer than 28 to 104 us.
`timescale 1ns/1ps
`default_nettype none
`include "sbcts_params.svh"
module sbcts_timing_supervisor
	import sbcts_pkg::*;
#(
	parameter int OSC_DIV           = `SBCTS_OSC_DIV,
	parameter int RST_LONG_TICKS    = `SBCTS_RST_LONG_TICKS,
	parameter int RST_SHORT_TICKS   = `SBCTS_RST_SHORT_TICKS,
	parameter int CLAMP_TICKS       = `SBCTS_CLAMP_TICKS,
	parameter int LIN_TXD_TICKS     = `SBCTS_LIN_TXD_TICKS,
	parameter int WB_CY_LONG_TICKS  = `SBCTS_WB_CY_LONG_TICKS,
	parameter int WB_CY_SHORT_TICKS = `SBCTS_WB_CY_SHORT_TICKS,
	parameter int WD_MS_TICKS       = `SBCTS_WD_MS_TICKS
) (
	// clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   sys_rst,
	// mode and watchdog control
	input  wire sbcts_mode_type         op_mode,
	input  wire logic                   wd_window_mode,
	input  wire logic [`SBCTS_NWP_W-1:0] nominal_period_field,
	input  wire logic                   wd_trigger,
	input  wire logic                   watchdog_disable_pin,
	// microcontroller supply
	input  wire logic                   mcu_supply_active,
	input  wire logic                   mcu_supply_low,
	// system reset pin, open drain
	input  wire logic                   system_reset_pin_in,
	output logic                        system_reset_pin_out,
	output logic                        system_reset_pin_oe,
	input  wire logic                   rst_pullup_short,
	// local wake inputs
	input  wire logic                   local_wake_input_a,
	input  wire logic                   local_wake_input_b,
	// can channel
	input  wire logic                   can_online,
	input  wire logic                   can_transmit_input,
	input  wire logic                   can_bus_dominant,
	// lin channels
	input  wire logic                   lin_online_a,
	input  wire logic                   lin_online_b,
	input  wire logic                   lin_transmit_input_a,
	input  wire logic                   lin_transmit_input_b,
	input  wire logic                   lin_bus_dominant_a,
	input  wire logic                   lin_bus_dominant_b,
	// wake bias
	input  wire logic                   wake_bias_cycle_select,
	output logic                        wake_bias_output,
	// status
	output sbcts_wake_type              wake_events,
	output sbcts_fault_type             fault_flags,
	output logic                        watchdog_disabled
);

	// ------------------------------------------------------------
	// oscillator tick
	// ------------------------------------------------------------
	logic [15:0] div_cnt;
	logic        tick;

	assign tick = (div_cnt == 16'(OSC_DIV - 1));

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			div_cnt <= 16'h0000;
		else if (tick)
			div_cnt <= 16'h0000;
		else
			div_cnt <= div_cnt + 16'h0001;
	end

	// ------------------------------------------------------------
	// hold timers
	// ------------------------------------------------------------
	localparam int T_RCL = 0;
	localparam int T_SCL = 1;
	localparam int T_CTX = 2;
	localparam int T_LTA = 3;
	localparam int T_LTB = 4;
	localparam int T_LWA = 5;
	localparam int T_LWB = 6;
	localparam int T_WKA = 7;
	localparam int T_WKB = 8;
	localparam int T_WDO = 9;
	localparam int NT    = 10;

	logic [NT-1:0] hold;
	logic [NT-1:0] expired;
	sbcts_cnt_type limit [NT];
	logic [1:0]    wake_filt;
	logic          rst_active;

	assign hold[T_RCL] = !watchdog_disabled && !rst_active && !system_reset_pin_in;
	assign hold[T_SCL] = mcu_supply_active && !watchdog_disabled && mcu_supply_low;
	assign hold[T_CTX] = can_online && !can_transmit_input;
	assign hold[T_LTA] = lin_online_a && !lin_transmit_input_a;
	assign hold[T_LTB] = lin_online_b && !lin_transmit_input_b;
	assign hold[T_LWA] = (op_mode != SBCTS_NORMAL) && lin_bus_dominant_a;
	assign hold[T_LWB] = (op_mode != SBCTS_NORMAL) && lin_bus_dominant_b;
	assign hold[T_WKA] = local_wake_input_a != wake_filt[0];
	assign hold[T_WKB] = local_wake_input_b != wake_filt[1];
	assign hold[T_WDO] = watchdog_disable_pin != watchdog_disabled;

	// every limit is an oscillator tick count
	assign limit[T_RCL] = sbcts_cnt_type'(CLAMP_TICKS);
	assign limit[T_SCL] = sbcts_cnt_type'(CLAMP_TICKS);
	assign limit[T_CTX] = sbcts_cnt_type'(`SBCTS_CAN_TXD_TICKS);
	assign limit[T_LTA] = sbcts_cnt_type'(LIN_TXD_TICKS);
	assign limit[T_LTB] = sbcts_cnt_type'(LIN_TXD_TICKS);
	assign limit[T_LWA] = sbcts_cnt_type'(`SBCTS_LIN_WAKE_TICKS);
	assign limit[T_LWB] = sbcts_cnt_type'(`SBCTS_LIN_WAKE_TICKS);
	assign limit[T_WKA] = sbcts_cnt_type'(`SBCTS_WAKE_TICKS);
	assign limit[T_WKB] = sbcts_cnt_type'(`SBCTS_WAKE_TICKS);
	assign limit[T_WDO] = sbcts_cnt_type'(`SBCTS_WATCHDOG_DISABLE_PIN_TICKS);

	genvar gi;
	generate
		for (gi = 0; gi < NT; gi++) begin : g_tmr
			sbcts_hold_timer u_tmr (
				.clk_sys (clk_sys),
				.sys_rst (sys_rst),
				.tick    (tick),
				.hold    (hold[gi]),
				.limit   (limit[gi]),
				.expired (expired[gi])
			);
		end
	endgenerate

	// filtered levels flip once the new level has lasted
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			wake_filt         <= `SBCTS_WAKE_FILT_INIT;
			watchdog_disabled <= `SBCTS_WATCHDOG_DISABLE_PIN_INIT;
		end else begin
			if (expired[T_WKA])
				wake_filt[0] <= ~wake_filt[0];
			if (expired[T_WKB])
				wake_filt[1] <= ~wake_filt[1];
			if (expired[T_WDO])
				watchdog_disabled <= ~watchdog_disabled;
		end
	end

	// ------------------------------------------------------------
	// window watchdog
	// ------------------------------------------------------------
	function automatic sbcts_cnt_type wd_period(input logic [`SBCTS_NWP_W-1:0] f);
		int ms;
		case (f)
			3'h0:    ms = `SBCTS_WD_P0_MS;
			3'h1:    ms = `SBCTS_WD_P1_MS;
			3'h2:    ms = `SBCTS_WD_P2_MS;
			3'h3:    ms = `SBCTS_WD_P3_MS;
			3'h4:    ms = `SBCTS_WD_P4_MS;
			3'h5:    ms = `SBCTS_WD_P5_MS;
			3'h6:    ms = `SBCTS_WD_P6_MS;
			default: ms = `SBCTS_WD_P7_MS;
		endcase
		return sbcts_cnt_type'(ms * WD_MS_TICKS);
	endfunction

	sbcts_cnt_type wd_cnt;
	sbcts_cnt_type wd_period_now;
	sbcts_cnt_type wd_half;
	logic          wd_active;
	logic          wd_early;
	logic          wd_overflow;

	// half and full period sit inside both tolerance bands
	assign wd_period_now = wd_period(nominal_period_field);
	assign wd_half       = wd_period_now >> 1;
	assign wd_active     = wd_window_mode && !watchdog_disabled && !rst_active;
	assign wd_early      = wd_active && wd_trigger && (op_mode == SBCTS_NORMAL) && (wd_cnt < wd_half);
	assign wd_overflow   = wd_active && (wd_cnt >= wd_period_now);

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			wd_cnt <= '0;
		else if (!wd_active || wd_trigger || wd_overflow)
			wd_cnt <= '0;
		else if (tick)
			wd_cnt <= wd_cnt + 1'b1;
	end

	// ------------------------------------------------------------
	// system reset pulse
	// ------------------------------------------------------------
	sbcts_cnt_type rst_cnt;
	sbcts_cnt_type rst_len;

	// pulse length is fixed by what pull-up the board fits
	assign rst_len = rst_pullup_short ? sbcts_cnt_type'(RST_SHORT_TICKS) : sbcts_cnt_type'(RST_LONG_TICKS);

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rst_active <= `SBCTS_RST_ACTIVE_INIT;
			rst_cnt    <= '0;
		end else if (wd_early || wd_overflow) begin
			rst_active <= 1'b1;
			rst_cnt    <= '0;
		end else if (rst_active && tick) begin
			if (rst_cnt >= rst_len - 1'b1) begin
				rst_active <= 1'b0;
				rst_cnt    <= '0;
			end else begin
				rst_cnt <= rst_cnt + 1'b1;
			end
		end
	end

	assign system_reset_pin_out = 1'b0;
	assign system_reset_pin_oe  = rst_active;

	// ------------------------------------------------------------
	// can bus wake-up pattern
	// ------------------------------------------------------------
	sbcts_canwk_type can_st;
	sbcts_canwk_type next_can_st;
	logic            can_dom_q;
	logic [9:0]      can_pcnt;
	logic [9:0]      can_to_cnt;
	logic            can_edge;
	logic            can_long;
	logic            can_to;
	logic            can_wake;

	assign can_edge = can_bus_dominant != can_dom_q;
	assign can_long = can_pcnt >= 10'(`SBCTS_CAN_PULSE_CYC);
	assign can_to   = can_to_cnt >= 10'(`SBCTS_CAN_WAKE_TO_TICKS);

	// pulses below the oscillator grain are timed on clk_sys
	always_comb begin
		next_can_st = can_st;
		can_wake    = 1'b0;
		case (can_st)
			CW_IDLE: begin
				if (!can_bus_dominant && !can_edge && can_long)
					next_can_st = CW_REC;
			end
			CW_REC: begin
				if (can_edge && !can_bus_dominant)
					next_can_st = can_long ? CW_DOM : CW_IDLE;
			end
			CW_DOM: begin
				if (can_to)
					next_can_st = CW_IDLE;
				else if (can_edge && can_bus_dominant)
					next_can_st = can_long ? CW_CONF : CW_IDLE;
			end
			CW_CONF: begin
				if (can_to) begin
					next_can_st = CW_IDLE;
				end else if (can_bus_dominant && !can_edge && can_long) begin
					next_can_st = CW_IDLE;
					can_wake    = 1'b1;
				end
			end
			default: next_can_st = CW_IDLE;
		endcase
		if (op_mode != SBCTS_SLEEP) begin
			next_can_st = CW_IDLE;
			can_wake    = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			can_st     <= CW_IDLE;
			can_dom_q  <= 1'b0;
			can_pcnt   <= 10'h000;
			can_to_cnt <= 10'h000;
		end else begin
			can_st    <= next_can_st;
			can_dom_q <= can_bus_dominant;
			if (can_edge)
				can_pcnt <= 10'h000;
			else if (!can_long)
				can_pcnt <= can_pcnt + 10'h001;
			if (next_can_st != CW_DOM && next_can_st != CW_CONF)
				can_to_cnt <= 10'h000;
			else if (tick && !can_to)
				can_to_cnt <= can_to_cnt + 10'h001;
		end
	end

	// ------------------------------------------------------------
	// wake events and fault flags
	// ------------------------------------------------------------
	logic [1:0]      lin_wk_q;
	sbcts_wake_type  next_wake_events;
	sbcts_fault_type next_fault_flags;

	assign next_wake_events = '{
		local_a: expired[T_WKA],
		local_b: expired[T_WKB],
		can:     can_wake,
		lin_a:   expired[T_LWA] && !lin_wk_q[0],
		lin_b:   expired[T_LWB] && !lin_wk_q[1]
	};
	assign next_fault_flags = '{
		reset_clamp:      expired[T_RCL],
		supply_clamp:     expired[T_SCL],
		can_tx_timeout:   expired[T_CTX],
		lin_a_tx_timeout: expired[T_LTA],
		lin_b_tx_timeout: expired[T_LTB]
	};

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			lin_wk_q    <= 2'h0;
			wake_events <= '0;
			fault_flags <= '0;
		end else begin
			lin_wk_q    <= {expired[T_LWB], expired[T_LWA]};
			wake_events <= next_wake_events;
			fault_flags <= next_fault_flags;
		end
	end

	// ------------------------------------------------------------
	// wake bias strobe
	// ------------------------------------------------------------
	sbcts_cnt_type wb_cnt;
	sbcts_cnt_type wb_cycle;

	assign wb_cycle = wake_bias_cycle_select ? sbcts_cnt_type'(WB_CY_LONG_TICKS)
	                                         : sbcts_cnt_type'(WB_CY_SHORT_TICKS);

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			wb_cnt           <= '0;
			wake_bias_output <= `SBCTS_WAKE_BIAS_OUTPUT_INIT;
		end else begin
			if (tick)
				wb_cnt <= (wb_cnt >= wb_cycle - 1'b1) ? '0 : wb_cnt + 1'b1;
			wake_bias_output <= wb_cnt >= sbcts_cnt_type'(`SBCTS_WB_LOW_TICKS);
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	sequence s_window_trigger;
		wd_active && wd_trigger && (wd_cnt >= wd_half) && (wd_cnt < wd_period_now);
	endsequence

	property p_early_reset;
		wd_active && wd_trigger && op_mode == SBCTS_NORMAL && wd_cnt < wd_half |=> system_reset_pin_oe;
	endproperty
	a_early_reset: assert property (p_early_reset) else $error("early trigger gave no reset");

	property p_window_restart;
		s_window_trigger |=> (wd_cnt == '0) && !system_reset_pin_oe;
	endproperty
	a_window_restart: assert property (p_window_restart) else $error("window trigger misbehaved");

	property p_overflow;
		wd_active && !wd_trigger && wd_cnt >= wd_period_now |=> system_reset_pin_oe;
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow gave no reset");

	property p_early_normal_only;
		wd_active && wd_trigger && op_mode != SBCTS_NORMAL && wd_cnt < wd_period_now |=> !system_reset_pin_oe;
	endproperty
	a_early_normal_only: assert property (p_early_normal_only) else $error("early reset outside normal");

	property p_period_bound;
		wd_active |-> wd_cnt <= wd_period(nominal_period_field);
	endproperty
	a_period_bound: assert property (p_period_bound) else $error("watchdog ran past period");

	property p_reset_length;
		$fell(system_reset_pin_oe) |-> $past(rst_cnt) == $past(rst_len) - 1'b1;
	endproperty
	a_reset_length: assert property (p_reset_length) else $error("reset pulse length wrong");

	property p_reset_clamp;
		fault_flags.reset_clamp |-> $past(!system_reset_pin_in && !system_reset_pin_oe && !watchdog_disabled);
	endproperty
	a_reset_clamp: assert property (p_reset_clamp) else $error("clamp flag without cause");

	property p_can_timeout;
		can_to && (can_st == CW_DOM || can_st == CW_CONF) |=> can_st == CW_IDLE && !wake_events.can;
	endproperty
	a_can_timeout: assert property (p_can_timeout) else $error("can wake kept after timeout");

	property p_can_txd;
		fault_flags.can_tx_timeout |-> $past(can_online && !can_transmit_input);
	endproperty
	a_can_txd: assert property (p_can_txd) else $error("can tx flag without cause");

	property p_wake_bias_output_low;
		$rose(wake_bias_output) |-> $past(wb_cnt, 2) == sbcts_cnt_type'(`SBCTS_WB_LOW_TICKS) - 1'b1;
	endproperty
	a_wake_bias_output_low: assert property (p_wake_bias_output_low) else $error("wake bias low time wrong");

endmodule // sbcts_timing_supervisor
`default_nettype wire

// File: tb/sbcts_mcu_model.sv
// microcontroller model: watchdog service and transmit pins
`timescale 1ns/1ps
`default_nettype none
`include "sbcts_params.svh"
module sbcts_mcu_model
	import sbcts_pkg::*;
(
	// clock
	input  wire logic                    clk_sys,
	// device side
	output logic                         wd_trigger,
	output logic [`SBCTS_NWP_W-1:0]      nominal_period_field,
	output logic                         can_transmit_input,
	output logic                         lin_transmit_input_a,
	output logic                         lin_transmit_input_b
);
	initial begin
		wd_trigger = 1'h0;
		nominal_period_field = 3'h0;
		can_transmit_input = 1'h1;
		lin_transmit_input_a = 1'h1;
		lin_transmit_input_b = 1'h1;
	end
	// caller picks n to place the pulse early or inside the window
	task automatic service(input int n);
		repeat (n) @(negedge clk_sys);
		wd_trigger = 1'h1;
		@(negedge clk_sys);
		wd_trigger = 1'h0;
	endtask
	task automatic tx(input logic c, input logic a, input logic b);
		can_transmit_input = c;
		lin_transmit_input_a = a;
		lin_transmit_input_b = b;
	endtask
endmodule // sbcts_mcu_model
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the sbc timing supervisor
`timescale 1ns/1ps
`default_nettype none
`include "sbcts_params.svh"
module testbench
	import sbcts_pkg::*;
;
	// counts shortened so the run stays small
	localparam int DIV = 4, RL = 40, RS = 10, CL = 50, LT = 30, WS = 200, WL = 300, WDMS = 2;
	localparam int PER = `SBCTS_WD_P0_MS * WDMS * DIV;
	sbcts_mode_type op_mode = SBCTS_NORMAL;
	logic clk_sys = 1'h0, sys_rst = 1'h1, wd_window_mode = 1'h0, watchdog_disable_pin = 1'h0, pin_hold = 1'h0;
	logic mcu_supply_active = 1'h0, mcu_supply_low = 1'h0, rst_pullup_short = 1'h0, can_online = 1'h0;
	logic local_wake_input_a = 1'h0, local_wake_input_b = 1'h0, can_bus_dominant = 1'h0;
	logic lin_online_a = 1'h0, lin_online_b = 1'h0, lin_bus_dominant_a = 1'h0, lin_bus_dominant_b = 1'h0;
	logic wake_bias_cycle_select = 1'h0;
	wire logic wd_trigger, can_transmit_input, lin_transmit_input_a, lin_transmit_input_b;
	wire logic system_reset_pin_oe, wake_bias_output, watchdog_disabled, system_reset_pin_in, system_reset_pin_out;
	wire logic [`SBCTS_NWP_W-1:0] nominal_period_field;
	wire sbcts_wake_type wake_events;
	wire sbcts_fault_type fault_flags;
	wire logic [9:0] obs;
	int n_fail = 0, total_checks = 0;
	// pin has a pull-up: low while the device or the board holds it
	assign system_reset_pin_in = !(system_reset_pin_oe || pin_hold);
	assign obs = {wake_bias_output, fault_flags.lin_a_tx_timeout, fault_flags.can_tx_timeout, fault_flags.supply_clamp,
		fault_flags.reset_clamp, wake_events.lin_a, wake_events.can, wake_events.local_a, watchdog_disabled,
		system_reset_pin_oe};
	sbcts_timing_supervisor #(.OSC_DIV(DIV), .RST_LONG_TICKS(RL), .RST_SHORT_TICKS(RS), .CLAMP_TICKS(CL),
		.LIN_TXD_TICKS(LT), .WB_CY_LONG_TICKS(WL), .WB_CY_SHORT_TICKS(WS), .WD_MS_TICKS(WDMS)) i_dut (
		.clk_sys, .sys_rst, .op_mode, .wd_window_mode, .nominal_period_field, .wd_trigger,
		.watchdog_disable_pin, .mcu_supply_active, .mcu_supply_low, .system_reset_pin_in,
		.system_reset_pin_out, .system_reset_pin_oe, .rst_pullup_short, .local_wake_input_a,
		.local_wake_input_b, .can_online, .can_transmit_input, .can_bus_dominant, .lin_online_a,
		.lin_online_b, .lin_transmit_input_a, .lin_transmit_input_b, .lin_bus_dominant_a,
		.lin_bus_dominant_b, .wake_bias_cycle_select, .wake_bias_output, .wake_events, .fault_flags,
		.watchdog_disabled);
	sbcts_mcu_model i_uc (.clk_sys, .wd_trigger, .nominal_period_field, .can_transmit_input,
		.lin_transmit_input_a, .lin_transmit_input_b);
	initial begin
		clk_sys = 1'h0;
		forever #2 clk_sys = ~clk_sys;
	end
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// cycles until obs[idx] shows lvl; must land in lo..hi
	task automatic wait_len(input int idx, input logic lvl, input int lo, input int hi);
		int k;
		k = 0;
		while (obs[idx] !== lvl && k <= hi) begin
			@(negedge clk_sys);
			k++;
		end
		total_checks++;
		if (k < lo || k > hi) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h..%h", $time, k, lo, hi);
		end
		if (k > hi)
			conclude();
	endtask
	task automatic svc_chk(input int n, input logic exp);
		i_uc.service(n);
		repeat (2) @(negedge clk_sys);
		chk(system_reset_pin_oe, exp);
	endtask
	// three alternating phases, then dominant; gap sets the last recessive
	task automatic can_seq(input int gap);
		for (int i = 0; i < 3; i++) begin
			can_bus_dominant = i[0];
			repeat (i == 2 ? gap : 440) @(negedge clk_sys);
		end
		can_bus_dominant = 1'h1;
	endtask
	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		repeat (4) @(negedge clk_sys);
		chk(system_reset_pin_oe, 1'h1);
		chk(system_reset_pin_out, 1'h0);
		sys_rst = 1'h0;
		wait_len(0, 1'h0, RL * DIV - DIV, RL * DIV + DIV);
		wd_window_mode = 1'h1;
		repeat (3) svc_chk(44, 1'h0);
		rst_pullup_short = 1'h1;
		svc_chk(12, 1'h1);
		wait_len(0, 1'h0, RS * DIV - DIV - 3, RS * DIV + DIV);
		wait_len(0, 1'h1, PER - DIV, PER + DIV + 2);
		wait_len(0, 1'h0, RS * DIV - DIV, RS * DIV + DIV);
		op_mode = SBCTS_STANDBY;
		svc_chk(12, 1'h0);
		wait_len(0, 1'h1, PER - DIV - 3, PER + DIV + 2);
		wait_len(0, 1'h0, RS * DIV - DIV, RS * DIV + DIV);
		op_mode = SBCTS_NORMAL;
		wd_window_mode = 1'h0;
		svc_chk(3, 1'h0);
		repeat (PER + 20) @(negedge clk_sys);
		chk(system_reset_pin_oe, 1'h0);
		pin_hold = 1'h1;
		wait_len(5, 1'h1, CL * DIV - DIV, CL * DIV + DIV + 2);
		pin_hold = 1'h0;
		mcu_supply_active = 1'h1;
		mcu_supply_low = 1'h1;
		wait_len(6, 1'h1, CL * DIV - DIV, CL * DIV + DIV + 2);
		mcu_supply_low = 1'h0;
		lin_online_a = 1'h1;
		lin_online_b = 1'h1;
		can_online = 1'h1;
		i_uc.tx(1'h1, 1'h0, 1'h0);
		wait_len(8, 1'h1, LT * DIV - DIV, LT * DIV + DIV + 2);
		chk(fault_flags.lin_b_tx_timeout, 1'h1);
		i_uc.tx(1'h0, 1'h1, 1'h1);
		wait_len(7, 1'h1, `SBCTS_CAN_TXD_TICKS * DIV - DIV, `SBCTS_CAN_TXD_TICKS * DIV + DIV + 2);
		local_wake_input_a = 1'h1;
		local_wake_input_b = 1'h1;
		wait_len(2, 1'h1, `SBCTS_WAKE_TICKS * DIV - DIV, `SBCTS_WAKE_TICKS * DIV + DIV + 2);
		chk(wake_events.local_b, 1'h1);
		watchdog_disable_pin = 1'h1;
		wait_len(1, 1'h1, `SBCTS_WATCHDOG_DISABLE_PIN_TICKS * DIV - DIV, `SBCTS_WATCHDOG_DISABLE_PIN_TICKS * DIV + DIV + 2);
		op_mode = SBCTS_SLEEP;
		lin_bus_dominant_a = 1'h1;
		lin_bus_dominant_b = 1'h1;
		wait_len(4, 1'h1, `SBCTS_LIN_WAKE_TICKS * DIV - DIV, `SBCTS_LIN_WAKE_TICKS * DIV + DIV + 2);
		chk(wake_events.lin_b, 1'h1);
		can_seq(440);
		wait_len(3, 1'h1, `SBCTS_CAN_PULSE_CYC - 3, `SBCTS_CAN_PULSE_CYC + 3);
		can_seq(1800);
		repeat (`SBCTS_CAN_PULSE_CYC + 2) @(negedge clk_sys);
		chk(wake_events.can, 1'h0);
		wait_len(9, 1'h0, 0, WS * DIV + DIV);
		wait_len(9, 1'h1, 0, WS * DIV + DIV);
		wait_len(9, 1'h0, (WS - `SBCTS_WB_LOW_TICKS) * DIV - DIV, (WS - `SBCTS_WB_LOW_TICKS) * DIV + DIV);
		wait_len(9, 1'h1, `SBCTS_WB_LOW_TICKS * DIV - DIV, `SBCTS_WB_LOW_TICKS * DIV + DIV);
		wake_bias_cycle_select = 1'h1;
		wait_len(9, 1'h0, (WL - `SBCTS_WB_LOW_TICKS) * DIV - DIV, (WL - `SBCTS_WB_LOW_TICKS) * DIV + DIV);
		conclude();
	end
endmodule // testbench
`default_nettype wire
